//--- src/pcicsr_top.sv
`timescale 1ns/1ps
`include "pcicsr_consts.svh"

module pcicsr_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic backend_int,
    input wire logic sys_err_event,
    input wire logic parity_err_det,
    input wire logic acting_master,
    input wire logic parity_error_pin_in,
    input wire logic master_abort_event,
    input wire logic target_abort_event,
    output logic interrupt_request_pin_o,
    output logic interrupt_request_pin_oe,
    output logic system_error_pin_o,
    output logic system_error_pin_oe,
    output logic parity_error_pin_o,
    output logic parity_error_pin_oe,
    output logic master_enable,
    output logic memory_decode_enable,
    output logic special_cycle_monitor,
    output logic write_invalidate_enable,
    output logic inout_space_enable,
    output logic back_to_back_enable,
    output logic address_stepping_control,
    output logic [1:0] select_timing
);
    pcicsr_pkg::pcicsr_state_s st;
    pcicsr_pkg::pcicsr_state_s next_st;
    pcicsr_ctl_if ctl ();
    logic hit;
    logic [15:0] cmd_val;
    logic [15:0] stat_val;
    logic par_pin_seen;
    logic fixed_lo;

    // ------------------------------------------------------------
    // read views; hardwired and reserved bits are constants
    // ------------------------------------------------------------
    assign hit = (cfg_addr == `PCICSR_OFF_CMDSTAT);
    assign fixed_lo = 1'h0;

    always_comb begin
        cmd_val = `PCICSR_ZERO_HALF; // see RULE17
        cmd_val[`PCICSR_CMD_INT_MASK] = st.int_mask;
        cmd_val[`PCICSR_CMD_BTOB] = fixed_lo; // see RULE2
        cmd_val[`PCICSR_CMD_SYSTEM_ERROR_DRIVE_ENABLE] = st.system_error_drive_enable;
        cmd_val[`PCICSR_CMD_STEP] = fixed_lo; // see RULE4
        cmd_val[`PCICSR_CMD_PAR_RESP] = st.par_resp;
        cmd_val[`PCICSR_CMD_PALETTE] = fixed_lo; // see RULE6
        cmd_val[`PCICSR_CMD_WR_INV] = st.wr_inv;
        cmd_val[`PCICSR_CMD_SPC_MON] = st.spc_mon;
        cmd_val[`PCICSR_CMD_MASTER] = st.master;
        cmd_val[`PCICSR_CMD_MEM_DEC] = st.mem_dec;
        cmd_val[`PCICSR_CMD_IO] = fixed_lo; // see RULE11
    end

    always_comb begin
        stat_val = `PCICSR_ZERO_HALF; // see RULE17
        stat_val[`PCICSR_ST_DET_PAR] = st.det_par;
        stat_val[`PCICSR_ST_SIG_SYS] = st.sig_sys;
        stat_val[`PCICSR_ST_RCV_MABT] = st.rcv_mabt;
        stat_val[`PCICSR_ST_RCV_TABT] = st.rcv_tabt;
        stat_val[`PCICSR_ST_SIG_TABT] = fixed_lo; // target abort is never issued
        stat_val[`PCICSR_ST_SEL_HI:`PCICSR_ST_SEL_LO] = `PCICSR_SEL_MEDIUM; // see RULE15
        stat_val[`PCICSR_ST_MST_PAR] = st.mst_par;
        stat_val[`PCICSR_ST_BTOB_CAP] = fixed_lo;
        stat_val[`PCICSR_ST_CAP66] = `PCICSR_CAP66_VAL;
        stat_val[`PCICSR_ST_CAP_LIST] = `PCICSR_CAP_LIST_VAL;
        stat_val[`PCICSR_ST_INT_STAT] = st.int_stat; // see RULE13
    end

    // the observed parity pin is the two-stage synced input, or our own detected parity error while parity response is on
    assign par_pin_seen = st.perr_s2 | (parity_err_det & st.par_resp);

    // ------------------------------------------------------------
    // next state: config writes, sticky flags, read data
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.perr_s1 = parity_error_pin_in;
        next_st.perr_s2 = st.perr_s1;
        next_st.int_stat = backend_int; // mask never touches this flag, see RULE13
        next_st.rvalid = cfg_rd;
        next_st.rdata = `PCICSR_ZERO_WORD;
        if (cfg_rd && hit) begin
            next_st.rdata = {stat_val, cmd_val};
        end
        // writable command bits only; others are dropped, see RULE17
        if (cfg_wr && hit && cfg_be[1]) begin
            next_st.int_mask = cfg_wdata[`PCICSR_CMD_INT_MASK];
            next_st.system_error_drive_enable = cfg_wdata[`PCICSR_CMD_SYSTEM_ERROR_DRIVE_ENABLE];
        end
        if (cfg_wr && hit && cfg_be[0]) begin
            next_st.par_resp = cfg_wdata[`PCICSR_CMD_PAR_RESP];
            next_st.wr_inv = cfg_wdata[`PCICSR_CMD_WR_INV];
            next_st.spc_mon = cfg_wdata[`PCICSR_CMD_SPC_MON];
            next_st.master = cfg_wdata[`PCICSR_CMD_MASTER];
            next_st.mem_dec = cfg_wdata[`PCICSR_CMD_MEM_DEC];
        end
        // status flags clear on writing one; a same-cycle event still sets
        // clears come first so a flag raised in the clearing cycle is never lost
        if (cfg_wr && hit && cfg_be[3]) begin
            if (cfg_wdata[`PCICSR_ST_BASE + `PCICSR_ST_DET_PAR]) next_st.det_par = 1'h0;
            if (cfg_wdata[`PCICSR_ST_BASE + `PCICSR_ST_SIG_SYS]) next_st.sig_sys = 1'h0;
            if (cfg_wdata[`PCICSR_ST_BASE + `PCICSR_ST_RCV_MABT]) next_st.rcv_mabt = 1'h0;
            if (cfg_wdata[`PCICSR_ST_BASE + `PCICSR_ST_RCV_TABT]) next_st.rcv_tabt = 1'h0;
        end
        if (cfg_wr && hit && cfg_be[2]) begin
            if (cfg_wdata[`PCICSR_ST_BASE + `PCICSR_ST_MST_PAR]) next_st.mst_par = 1'h0;
        end
        if (parity_err_det) begin
            next_st.det_par = 1'h1; // see RULE16 see RULE5
        end
        if (sys_err_event && st.system_error_drive_enable) begin
            next_st.sig_sys = 1'h1; // see RULE3
        end
        if (master_abort_event) begin
            next_st.rcv_mabt = 1'h1;
        end
        if (target_abort_event) begin
            next_st.rcv_tabt = 1'h1;
        end
        if (par_pin_seen && acting_master && st.par_resp) begin
            next_st.mst_par = 1'h1; // see RULE14 see RULE12
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // pin driver requests
    // ------------------------------------------------------------
    assign ctl.int_pending = st.int_stat & ~st.int_mask; // see RULE1 see RULE13
    assign ctl.sys_err_req = sys_err_event & st.system_error_drive_enable; // see RULE3
    assign ctl.par_err_req = parity_err_det & st.par_resp; // see RULE5 see RULE12

    pcicsr_pins u_pcicsr_pins (
        .clk(clk),
        .rst_n(rst_n),
        .ctl(ctl.pins),
        .intr_oe(interrupt_request_pin_oe),
        .serr_oe(system_error_pin_oe),
        .perr_oe(parity_error_pin_oe)
    );

    // ------------------------------------------------------------
    // outputs straight from flops or constants
    // ------------------------------------------------------------
    assign cfg_rdata = st.rdata;
    assign cfg_rvalid = st.rvalid;
    assign interrupt_request_pin_o = 1'h0; // open drain: only ever pulls low
    assign system_error_pin_o = 1'h0;
    assign parity_error_pin_o = 1'h0;
    assign master_enable = st.master; // see RULE9
    assign memory_decode_enable = st.mem_dec; // see RULE10
    assign special_cycle_monitor = st.spc_mon; // see RULE8
    assign write_invalidate_enable = st.wr_inv; // see RULE7
    assign inout_space_enable = fixed_lo; // see RULE11
    assign back_to_back_enable = fixed_lo; // see RULE2
    assign address_stepping_control = fixed_lo; // see RULE4
    assign select_timing = `PCICSR_SEL_MEDIUM; // see RULE15

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_intr_masked: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
        st.int_mask && $stable(st.int_mask) |=> !interrupt_request_pin_oe)
        else $error("interrupt pin driven while masked");
    a_btob_zero: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
        cfg_rvalid && $past(cfg_rd && hit) |-> !cfg_rdata[`PCICSR_CMD_BTOB])
        else $error("back-to-back bit read as one");
    a_serr_gated: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
        sys_err_event && !st.system_error_drive_enable |=> !system_error_pin_oe)
        else $error("system error driven while disabled");
    a_hardwired_read: assert property (@(posedge clk) disable iff (!rst_n) // see RULE17
        cfg_rd && hit |=> cfg_rdata[15:11] == 5'h00 && cfg_rdata[7] == 1'h0
        && cfg_rdata[5] == 1'h0 && cfg_rdata[0] == 1'h0 && cfg_rdata[18:16] == 3'h0)
        else $error("hardwired command bits not zero");
    a_perr_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see RULE5
        parity_err_det && !st.par_resp |=> !parity_error_pin_oe && st.det_par)
        else $error("parity handling wrong with response disabled");
    a_det_par_set: assert property (@(posedge clk) disable iff (!rst_n) // see RULE16
        parity_err_det |=> st.det_par) else $error("parity detected flag missed");
    a_mst_par_cond: assert property (@(posedge clk) disable iff (!rst_n) // see RULE14
        $rose(st.mst_par) |-> $past(acting_master) && $past(st.par_resp))
        else $error("master parity flag set without cause");
    a_int_status: assert property (@(posedge clk) disable iff (!rst_n) // see RULE13
        backend_int ##1 backend_int && !st.int_mask |=> interrupt_request_pin_oe && st.int_stat)
        else $error("pending interrupt not reflected");
    a_sel_timing: assert property (@(posedge clk) disable iff (!rst_n) // see RULE15
        cfg_rd && hit |=> cfg_rdata[26:25] == 2'h1)
        else $error("select timing not medium");
    a_master_gate: assert property (@(posedge clk) disable iff (!rst_n) // see RULE9
        cfg_wr && hit && cfg_be[0] |=> master_enable == $past(cfg_wdata[`PCICSR_CMD_MASTER])
        && memory_decode_enable == $past(cfg_wdata[`PCICSR_CMD_MEM_DEC]))
        else $error("master or memory enable did not follow write");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n) // see RULE17
        cfg_rd && !hit |=> cfg_rvalid && cfg_rdata == `PCICSR_ZERO_WORD)
        else $error("unmapped read returned data");
    a_sig_sys_gate: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
        !st.sig_sys && !(sys_err_event && st.system_error_drive_enable) |=> !st.sig_sys)
        else $error("system error flag set without driven pin");
    a_cmd_follow: assert property (@(posedge clk) disable iff (!rst_n) // see RULE7
        cfg_wr && hit && cfg_be[0]
        |=> write_invalidate_enable == $past(cfg_wdata[`PCICSR_CMD_WR_INV])
        && special_cycle_monitor == $past(cfg_wdata[`PCICSR_CMD_SPC_MON]))
        else $error("write-invalidate or special cycle bit did not follow write");
endmodule // pcicsr_top

//--- src/pcicsr_consts.svh
// Contract
// RULE1: pin interrupt mask bit 10 clear lets pending interrupt drive the request pin.
// RULE2: back-to-back enable bit 9 reads 0; no fast back-to-back transactions.
// RULE3: system error drive enable bit 8 gates the system error pin driver.
// RULE4: address stepping control bit 7 reads 0; address stepping never used.
// RULE5: parity response bit 6 clear: flag still set, parity pin not driven.
// RULE6: palette snoop bit 5 always reads 0.
// RULE7: write-invalidate enable bit 4 permits Memory Write and Invalidate use.
// RULE8: special cycle monitor bit 3 clear ignores special cycles, set monitors.
// RULE9: master enable bit 2 gates initiating transactions as bus master.
// RULE10: memory decode enable bit 1 gates response to memory accesses.
// RULE11: I/O space enable bit 0 reads 0; never respond to I/O accesses.
// RULE12: status parity reporting follows the parity response enable setting.
// RULE13: interrupt pending flag follows back end; pin low only if flag and unmasked.
// RULE14: master parity flag needs parity pin seen while master and response enabled.
// RULE15: select timing field hardwired to medium decode timing.
// RULE16: parity detected flag set on every detected parity error.
// RULE17: writes to hardwired or reserved bits ignored; fixed values keep reading.
`ifndef PCICSR_CONSTS_SVH
`define PCICSR_CONSTS_SVH

// ----------------------------------------------------------------
// configuration space location
// ----------------------------------------------------------------
`define PCICSR_OFF_CMDSTAT 8'h04

// ----------------------------------------------------------------
// command register bit positions
// ----------------------------------------------------------------
`define PCICSR_CMD_INT_MASK 10
`define PCICSR_CMD_BTOB 9
`define PCICSR_CMD_SYSTEM_ERROR_DRIVE_ENABLE 8
`define PCICSR_CMD_STEP 7
`define PCICSR_CMD_PAR_RESP 6
`define PCICSR_CMD_PALETTE 5
`define PCICSR_CMD_WR_INV 4
`define PCICSR_CMD_SPC_MON 3
`define PCICSR_CMD_MASTER 2
`define PCICSR_CMD_MEM_DEC 1
`define PCICSR_CMD_IO 0

// ----------------------------------------------------------------
// status register bit positions and fixed values
// ----------------------------------------------------------------
`define PCICSR_ST_BASE 16
`define PCICSR_ST_DET_PAR 15
`define PCICSR_ST_SIG_SYS 14
`define PCICSR_ST_RCV_MABT 13
`define PCICSR_ST_RCV_TABT 12
`define PCICSR_ST_SIG_TABT 11
`define PCICSR_ST_SEL_HI 10
`define PCICSR_ST_SEL_LO 9
`define PCICSR_ST_MST_PAR 8
`define PCICSR_ST_BTOB_CAP 7
`define PCICSR_ST_CAP66 5
`define PCICSR_ST_CAP_LIST 4
`define PCICSR_ST_INT_STAT 3
`define PCICSR_SEL_MEDIUM 2'h1
`define PCICSR_CAP66_VAL 1'h0
`define PCICSR_CAP_LIST_VAL 1'h1
`define PCICSR_ZERO_WORD 32'h00000000
`define PCICSR_ZERO_HALF 16'h0000

`endif

//--- src/pcicsr_pkg.sv
package pcicsr_pkg;

    // register state of the command/status block
    typedef struct packed {
        logic int_mask;
        logic system_error_drive_enable;
        logic par_resp;
        logic wr_inv;
        logic spc_mon;
        logic master;
        logic mem_dec;
        logic det_par;
        logic sig_sys;
        logic rcv_mabt;
        logic rcv_tabt;
        logic mst_par;
        logic int_stat;
        logic perr_s1;
        logic perr_s2;
        logic [31:0] rdata;
        logic rvalid;
    } pcicsr_state_s;

    // pin driver state
    typedef struct packed {
        logic intr_oe;
        logic serr_oe;
        logic perr_oe;
    } pcicsr_pin_s;

endpackage

//--- src/pcicsr_ctl_if.sv
`timescale 1ns/1ps
// control handed from the register bank to the pin drivers
interface pcicsr_ctl_if;
    logic int_pending;
    logic sys_err_req;
    logic par_err_req;

    modport bank (output int_pending, output sys_err_req, output par_err_req);
    modport pins (input int_pending, input sys_err_req, input par_err_req);
endinterface

//--- src/pcicsr_pins.sv
`timescale 1ns/1ps
`include "pcicsr_consts.svh"

module pcicsr_pins (
    input wire logic clk,
    input wire logic rst_n,
    pcicsr_ctl_if.pins ctl,
    output logic intr_oe,
    output logic serr_oe,
    output logic perr_oe
);
    pcicsr_pkg::pcicsr_pin_s st;
    pcicsr_pkg::pcicsr_pin_s next_st;

    // ------------------------------------------------------------
    // open-drain drivers: enable high means the pin is pulled low
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.intr_oe = ctl.int_pending; // see RULE1 see RULE13
        next_st.serr_oe = ctl.sys_err_req; // see RULE3
        next_st.perr_oe = ctl.par_err_req; // see RULE5
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign intr_oe = st.intr_oe;
    assign serr_oe = st.serr_oe;
    assign perr_oe = st.perr_oe;

    a_intr_follows: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
        ctl.int_pending |=> intr_oe) else $error("interrupt pin not driven");
    a_serr_follows: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
        !ctl.sys_err_req |=> !serr_oe) else $error("system error pin driven without cause");
endmodule // pcicsr_pins

//--- verif/pcicsr_bus_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side bus agent and open-drain wiring
// ------------------------------------------------------------
module pcicsr_bus_model (
    input wire logic clk,
    input wire logic drive_perr,
    input wire logic intr_o,
    input wire logic intr_oe,
    input wire logic serr_o,
    input wire logic serr_oe,
    input wire logic perr_o,
    input wire logic perr_oe,
    output logic intr_n,
    output logic serr_n,
    output logic perr_n,
    output logic perr_seen
);
    logic agent_perr = 1'b0;
    // the agent moves its pin just after an edge, as a real bus agent would
    always @(posedge clk) begin
        agent_perr <= drive_perr;
    end
    // pull-ups: a released pin goes high, it never keeps a stale low
    assign intr_n = intr_oe ? intr_o : 1'b1;
    assign serr_n = serr_oe ? serr_o : 1'b1;
    assign perr_n = (perr_oe ? perr_o : 1'b1) & ~agent_perr;
    assign perr_seen = ~perr_n; // both parties can pull the parity pin
endmodule // pcicsr_bus_model

//--- verif/pcicsr_top_test.sv
`timescale 1ns/1ps
`include "pcicsr_consts.svh"
module pcicsr_top_test;
    logic clk, rst_n, cfg_wr, cfg_rd, cfg_rvalid, backend_int, sys_err_event, parity_err_det;
    logic acting_master, perr_seen, master_abort_event, target_abort_event, drive_perr;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic intr_oe, serr_oe, perr_oe, intr_n, serr_n, perr_n;
    logic intr_o, serr_o, perr_o;
    logic master_enable, memory_decode_enable, special_cycle_monitor, write_invalidate_enable;
    logic inout_space_enable, back_to_back_enable, address_stepping_control;
    logic [1:0] select_timing;
    logic [15:0] exp_cmd, exp_st;
    logic [31:0] rnd;
    integer seed = 32'h87962435;
    int n_errors = 0, tests_run = 0, cycles = 0;
    localparam logic [7:0] A = `PCICSR_OFF_CMDSTAT;

    pcicsr_top u_pcicsr_top (.clk(clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .backend_int(backend_int), .sys_err_event(sys_err_event),
        .parity_err_det(parity_err_det), .acting_master(acting_master),
        .parity_error_pin_in(perr_seen), .master_abort_event(master_abort_event),
        .target_abort_event(target_abort_event), .interrupt_request_pin_o(intr_o),
        .interrupt_request_pin_oe(intr_oe), .system_error_pin_o(serr_o),
        .system_error_pin_oe(serr_oe), .parity_error_pin_o(perr_o),
        .parity_error_pin_oe(perr_oe),
        .master_enable(master_enable), .memory_decode_enable(memory_decode_enable),
        .special_cycle_monitor(special_cycle_monitor),
        .write_invalidate_enable(write_invalidate_enable),
        .inout_space_enable(inout_space_enable), .back_to_back_enable(back_to_back_enable),
        .address_stepping_control(address_stepping_control), .select_timing(select_timing));

    pcicsr_bus_model u_pcicsr_bus_model (.clk(clk), .drive_perr(drive_perr), .intr_o(intr_o),
        .intr_oe(intr_oe), .serr_o(serr_o), .serr_oe(serr_oe), .perr_o(perr_o),
        .perr_oe(perr_oe), .intr_n(intr_n),
        .serr_n(serr_n), .perr_n(perr_n), .perr_seen(perr_seen));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // the whole run is about 110 cycles, so 4000 means a hang
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // expectations, compares and bus tasks
    // ------------------------------------------------------------
    // only bits 10,8 (lane 1) and 6..1 minus 5 (lane 0) take writes
    function automatic logic [15:0] next_cmd(logic [15:0] c, logic [3:0] be, logic [15:0] d);
        if (be[1]) c = (c & ~16'h0500) | (d & 16'h0500);
        if (be[0]) c = (c & ~16'h005E) | (d & 16'h005E);
        return c;
    endfunction
    function automatic logic [15:0] next_st(logic [15:0] s, logic [3:0] be, logic [15:0] d);
        if (be[3]) s = s & ~(d & 16'hF000);
        if (be[2]) s = s & ~(d & 16'h0100);
        return s;
    endfunction
    task automatic chk1(input string n, input logic e, input logic g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // called at a falling edge; returns at the falling edge after the take
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        if (a == A) begin
            exp_cmd = next_cmd(exp_cmd, be, d[15:0]);
            exp_st = next_st(exp_st, be, d[31:16]);
        end
    endtask
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] e);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk1("cfg_rvalid", 1'b1, cfg_rvalid);
        chk32("cfg_rdata", e, cfg_rdata);
    endtask
    // ev = {system error, parity detect, master abort, target abort}
    task automatic fire(input logic [3:0] ev);
        {sys_err_event, parity_err_det, master_abort_event, target_abort_event} = ev;
        @(negedge clk);
        {sys_err_event, parity_err_det, master_abort_event, target_abort_event} = 4'h0;
    endtask
    task automatic chk_outs;
        chk1("master_enable", exp_cmd[2], master_enable);
        chk1("memory_decode_enable", exp_cmd[1], memory_decode_enable);
        chk1("special_cycle_monitor", exp_cmd[3], special_cycle_monitor);
        chk1("write_invalidate_enable", exp_cmd[4], write_invalidate_enable);
        chk32("fixed_outs", 32'h1, {27'h0, inout_space_enable, back_to_back_enable,
            address_stepping_control, select_timing});
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, cfg_wr, cfg_rd, backend_int, acting_master, drive_perr} = 6'h0;
        {sys_err_event, parity_err_det, master_abort_event, target_abort_event} = 4'h0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        exp_cmd = 16'h0000;
        exp_st = 16'h0210;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        cfg_read(A, {exp_st, exp_cmd});
        chk_outs();
        // random writes hit hardwired bits too; read straight back after each
        for (int i = 0; i < 24; i++) begin
            rnd = $random(seed);
            cfg_write((i % 5 == 4) ? 8'h08 : A, rnd[3:0], $random(seed));
            cfg_read(A, {exp_st, exp_cmd});
            chk_outs();
        end
        // idle cycle so the read strobe is never lowered and raised in one step
        @(negedge clk);
        cfg_read(8'h3C, 32'h0);
        // read data and valid stand for one cycle only
        @(negedge clk);
        chk1("cfg_rvalid_low", 1'b0, cfg_rvalid);
        chk32("cfg_rdata_idle", 32'h0, cfg_rdata);
        // interrupt: pin follows pending flag only while unmasked
        cfg_write(A, 4'h3, 32'h0000_0144);
        backend_int = 1'b1;
        repeat (3) @(negedge clk);
        exp_st = exp_st | 16'h0008;
        chk1("intr_n", 1'b0, intr_n);
        cfg_write(A, 4'h2, 32'h0000_0400);
        @(negedge clk);
        chk1("intr_n", 1'b1, intr_n);
        cfg_read(A, {exp_st, exp_cmd});
        // system error with the driver off, then on
        fire(4'h8);
        chk1("serr_n", 1'b1, serr_n);
        cfg_write(A, 4'h2, 32'h0000_0500);
        fire(4'h8);
        chk1("serr_n", 1'b0, serr_n);
        @(negedge clk);
        chk1("serr_n", 1'b1, serr_n);
        exp_st = exp_st | 16'h4000;
        cfg_read(A, {exp_st, exp_cmd});
        // parity error as master with response on, then with response off
        acting_master = 1'b1;
        fire(4'h4);
        chk1("perr_n", 1'b0, perr_n);
        exp_st = exp_st | 16'h8100;
        repeat (4) @(negedge clk);
        cfg_read(A, {exp_st, exp_cmd});
        cfg_write(A, 4'hD, 32'hF100_0004);
        fire(4'h4);
        chk1("perr_n", 1'b1, perr_n);
        exp_st = exp_st | 16'h8000;
        repeat (4) @(negedge clk);
        cfg_read(A, {exp_st, exp_cmd});
        // parity pin pulled by another agent, as master and not
        cfg_write(A, 4'h1, 32'h0000_0044);
        @(negedge clk);
        for (int m = 0; m < 2; m++) begin
            cfg_write(A, 4'hC, 32'hF100_0000);
            acting_master = m[0];
            drive_perr = 1'b1;
            @(negedge clk);
            drive_perr = 1'b0;
            repeat (5) @(negedge clk);
            if (m == 1) exp_st = exp_st | 16'h0100;
            cfg_read(A, {exp_st, exp_cmd});
        end
        // abort flags set, then cleared by writing ones
        fire(4'h3);
        exp_st = exp_st | 16'h3000;
        cfg_read(A, {exp_st, exp_cmd});
        backend_int = 1'b0;
        cfg_write(A, 4'hC, 32'hFFFF_0000);
        @(negedge clk);
        exp_st = exp_st & ~16'h0008;
        cfg_read(A, {exp_st, exp_cmd});
        end_sim();
    end
endmodule // pcicsr_top_test
